/* File: sss_conv_model.sv */
// Converter and switch model answering each conversion request after a set latency.
module sss_conv_model (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        conv_start,
  input  wire [4:0]  sel_chan,
  input  wire [23:0] sw,
  input  wire [3:0]  lat,
  output logic       conv_done,
  output logic       conv_above,
  output logic [9:0] conv_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic       busy;
  // Outside a result the data lines toggle so stale values are never mistaken for fresh ones.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_above <= 1'b0;
      conv_value <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      conv_above <= ~conv_above;
      conv_value <= ~conv_value;
      if (conv_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_above <= sw[sel_chan];
        conv_value <= {sel_chan, 5'h15};
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

/* File: sss_regs.vh */
// Register offsets, field positions, reset values and timing constants for the scan sequencer.
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// Byte offsets of the word registers.
`define SSS_OFF_CONFIG      7'h00
`define SSS_OFF_ENABLE      7'h04
`define SSS_OFF_MODE        7'h08
`define SSS_OFF_INT_EN      7'h0C
`define SSS_OFF_WET_A       7'h10
`define SSS_OFF_WET_B       7'h14
`define SSS_OFF_WET_C       7'h18
`define SSS_OFF_INT_STAT    7'h1C
`define SSS_OFF_COMP_STATE  7'h20
`define SSS_OFF_CONV_A      7'h24
`define SSS_OFF_CONV_B      7'h28
`define SSS_OFF_STATUS      7'h2C
`define SSS_OFF_VALUE_BASE  7'h40
`define SSS_VALUE_COUNT     12

// Fields of the configuration register.
`define SSS_CFG_START       0
`define SSS_CFG_POLL        1
`define SSS_CFG_WIN_LO      4
`define SSS_CFG_WIN_HI      6
`define SSS_CFG_PER_LO      8
`define SSS_CFG_PER_HI      11
`define SSS_CFG_RESET       32'h0000_0000

// Channel count and converter width.
`define SSS_NCH             24
`define SSS_ADC_W           10

// Timing: the clock rate, the microsecond and millisecond steps.
`define SSS_CLK_HZ          50000000
`define SSS_US_PER_S        1000000
`define SSS_US_CYC          (`SSS_CLK_HZ / `SSS_US_PER_S)
`define SSS_MS_US           1000
`define SSS_WIN_MIN_US      64
`define SSS_PER_MIN_MS      2
`define SSS_STARTUP_US      200

`endif

/* File: sss_scan_monitor.sv */
// Checker of the scan sequencer's port behaviour, bound to the design.
module sss_scan_monitor (
  input wire       ref_clk,
  input wire       reset_n,
  input wire [6:0] avs_address,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       conv_start,
  input wire       conv_done,
  input wire [4:0] sel_chan,
  input wire       sel_adc,
  input wire       irq_n,
  input wire       state_change_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Steps of a bus request, a status read and a finished conversion.
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_int_read;
    avs_read && !avs_waitrequest && avs_address == 7'h1C && !conv_done && !$past(conv_done);
  endsequence
  sequence s_conv_seen;
    $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3);
  endsequence
  // Properties; p_answer, p_clear, p_flag_cause and p_irq_cause are built from the steps above.
  property p_answer;
    s_req |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  property p_rest;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  property p_sel_stable;
    conv_start |=> ($stable(sel_chan) && $stable(sel_adc)) [*2];
  endproperty
  property p_clear;
    s_int_read |=> irq_n && !state_change_flag;
  endproperty
  property p_irq_flag;
    !irq_n |-> state_change_flag;
  endproperty
  property p_flag_cause;
    $rose(state_change_flag) |-> s_conv_seen;
  endproperty
  property p_irq_cause;
    $fell(irq_n) |-> s_conv_seen;
  endproperty
  a_answer: assert property (p_answer) else $error("waitrequest answer not one cycle");
  a_rest: assert property (p_rest) else $error("waitrequest low without request");
  a_start_pulse: assert property (p_start_pulse) else $error("conv_start longer than one cycle");
  a_sel_stable: assert property (p_sel_stable) else $error("selection moved in conversion");
  a_clear: assert property (p_clear) else $error("status read did not clear interrupt");
  a_irq_flag: assert property (p_irq_flag) else $error("interrupt low without flag");
  a_flag_cause: assert property (p_flag_cause) else $error("flag rose without conversion");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without conversion");
endmodule

bind sss_scan_seq sss_scan_monitor u_mon (
  .ref_clk          (ref_clk),
  .reset_n          (reset_n),
  .avs_address      (avs_address),
  .avs_read         (avs_read),
  .avs_write        (avs_write),
  .avs_waitrequest  (avs_waitrequest),
  .conv_start       (conv_start),
  .conv_done        (conv_done),
  .sel_chan         (sel_chan),
  .sel_adc          (sel_adc),
  .irq_n            (irq_n),
  .state_change_flag(state_change_flag)
);

/* File: sss_scan_seq.v */
// Scan sequencer: wetting control, ordered sampling, reference states and change interrupt.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "sss_regs.vh"

// Summary of operation
// - Continuous start: currents on after delay, stay
// - Continuous: sample enabled inputs IN0 upward
// - Six wetting levels per input, three registers
// - Mode bit picks comparator or ADC
// - Store result, reuse as reference state
// - ADC inputs fill twelve value registers
// - First full scan always interrupts, sets flag
// - Resample interval follows programmed cycle time
// - Reading interrupt status clears it, releases line
// - Later scans interrupt only on changes
// - Zero level: no current, still compared
// - Polling: currents switched one input, ascending
// - Change sets flag; line needs channel enable
// - Start bit launches polling, standard scheme
// - Polling window 64 to 4096 microseconds
// - Sample at window end by input mode
// - Scan repeats every 2 to 4096 ms
// - Polling current flows only in window and conversion
// - Changes between windows go unseen
// - Cleared start bit zeroes filter counter
// - Thermal recovery restarts, new reference states
module sss_scan_seq #(
  parameter STARTUP_US = `SSS_STARTUP_US
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire [6:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        tsd_in,
  input  wire        conv_done,
  input  wire        conv_above,
  input  wire [9:0]  conv_value,
  output reg  [4:0]  sel_chan,
  output reg         sel_adc,
  output reg         conv_start,
  output reg  [23:0] wet_en,
  output reg  [71:0] wet_level,
  output reg         irq_n,
  output reg         state_change_flag
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_SEEK  = 3'h2;
  localparam ST_WET   = 3'h3;
  localparam ST_CONV  = 3'h4;
  localparam ST_WAIT  = 3'h5;

  // Software registers.
  reg [31:0] config_reg;
  reg [23:0] enable_reg;
  reg [23:0] mode_reg;
  reg [23:0] int_en_reg;
  // Scan state.
  reg [2:0]  state;
  reg [5:0]  idx;
  reg [3:0]  slot;
  reg        first_cycle;
  reg        wet_cont;
  reg [23:0] cur_state;
  reg [23:0] ref_state;
  reg [7:0]  filter_cnt;
  reg [9:0]  value_mem [0:11];
  reg        tsd_meta;
  reg        tsd_sync;
  reg        win_load;
  reg [12:0] win_val;
  reg        per_load;
  // Combinational helpers.
  reg [5:0]  found;
  reg        found_ok;
  reg [23:0] next_wet_en;
  reg [23:0] lvl_nz;
  reg [31:0] next_readdata;
  wire       us_tick;
  wire       ms_tick;
  wire       win_done;
  wire       per_done;
  wire       run_ok;
  wire       bus_take;
  wire       stat_read;
  wire       end_set;
  wire       end_irq;
  wire [23:0] chg;
  wire [2:0]  wet_window_sel;
  wire [3:0]  per_sel;
  integer    i, j, k;

  assign run_ok  = config_reg[`SSS_CFG_START] & ~tsd_sync;
  assign wet_window_sel = config_reg[`SSS_CFG_WIN_HI:`SSS_CFG_WIN_LO];
  assign per_sel = config_reg[`SSS_CFG_PER_HI:`SSS_CFG_PER_LO];
  assign bus_take  = (avs_read | avs_write) & ~avs_waitrequest;
  assign stat_read = avs_read & ~avs_waitrequest & (avs_address == `SSS_OFF_INT_STAT);

  // End-of-scan evaluation: changes against the reference, gated by enables.
  assign chg     = (cur_state ^ ref_state) & enable_reg;
  assign end_set = (state == ST_SEEK) & ~found_ok & run_ok & (first_cycle | (chg != 24'h0));
  assign end_irq = (state == ST_SEEK) & ~found_ok & run_ok &
                   (first_cycle | ((chg & int_en_reg) != 24'h0));

  // Microsecond and millisecond ticks from the one clock.
  sss_tick_div #(.DIV(`SSS_US_CYC), .W(10)) u_us_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .en      (1'b1),
    .tick    (us_tick)
  );

  sss_tick_div #(.DIV(`SSS_MS_US), .W(10)) u_ms_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .en      (us_tick),
    .tick    (ms_tick)
  );

  // Window timer counts microseconds for the startup delay and the wetting window.
  sss_tick_timer #(.W(13)) u_win_timer (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .tick     (us_tick),
    .load     (win_load),
    .load_val (win_val),
    .done     (win_done)
  );

  // Period timer counts milliseconds of the scan cycle time.
  sss_tick_timer #(.W(13)) u_per_timer (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .tick     (ms_tick),
    .load     (per_load),
    .load_val ((13'h0002 << per_sel)),
    .done     (per_done)
  );

  // Find the next enabled input at or above the scan index.
  always @* begin
    found    = 6'h00;
    found_ok = 1'b0;
    for (i = `SSS_NCH - 1; i >= 0; i = i - 1) begin
      if (enable_reg[i] && (i[5:0] >= idx)) begin
        found    = i[5:0];
        found_ok = 1'b1;
      end
    end
  end

  // Which inputs carry a non-zero wetting level.
  always @* begin
    lvl_nz = 24'h0;
    for (j = 0; j < `SSS_NCH; j = j + 1) begin
      lvl_nz[j] = (wet_level[3*j +: 3] != 3'h0);
    end
  end

  // Wetting current enables for both modes.
  always @* begin
    next_wet_en = 24'h0;
    if (run_ok && wet_cont) begin
      next_wet_en = enable_reg & lvl_nz;
    end else if (run_ok && (state == ST_WET || state == ST_CONV)) begin
      next_wet_en = (24'h000001 << sel_chan) & enable_reg & lvl_nz;
    end
  end

  // Read data multiplexer; unmapped offsets read as zero.
  always @* begin
    next_readdata = 32'h0;
    case (avs_address)
      `SSS_OFF_CONFIG:     next_readdata = config_reg;
      `SSS_OFF_ENABLE:     next_readdata = {8'h00, enable_reg};
      `SSS_OFF_MODE:       next_readdata = {8'h00, mode_reg};
      `SSS_OFF_INT_EN:     next_readdata = {8'h00, int_en_reg};
      `SSS_OFF_WET_A:      next_readdata = {2'h0, wet_level[29:0]};
      `SSS_OFF_WET_B:      next_readdata = {2'h0, wet_level[59:30]};
      `SSS_OFF_WET_C:      next_readdata = {20'h0, wet_level[71:60]};
      `SSS_OFF_INT_STAT:   next_readdata = {31'h0, state_change_flag};
      `SSS_OFF_COMP_STATE: next_readdata = {8'h00, ref_state & ~mode_reg};
      `SSS_OFF_CONV_A:     next_readdata = {20'h0, ref_state[11:0] & mode_reg[11:0]};
      `SSS_OFF_CONV_B:     next_readdata = {20'h0, ref_state[23:12] & mode_reg[23:12]};
      `SSS_OFF_STATUS:     next_readdata = {13'h0, first_cycle, filter_cnt, 2'h0,
                                            sel_chan, state[2:0]};
      default: begin
        if (avs_address >= `SSS_OFF_VALUE_BASE &&
            avs_address < `SSS_OFF_VALUE_BASE + 7'h30) begin
          next_readdata = {22'h0, value_mem[avs_address[5:2]]};
        end
      end
    endcase
  end

  // Bus slave: one wait cycle, then the answer with waitrequest low for one cycle.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? next_readdata : 32'h0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Register writes take effect at the edge that ends the request.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= `SSS_CFG_RESET;
      enable_reg <= 24'h0;
      mode_reg   <= 24'h0;
      int_en_reg <= 24'h0;
      wet_level  <= 72'h0;
    end else if (bus_take && avs_write) begin
      case (avs_address)
        `SSS_OFF_CONFIG: config_reg <= {20'h0, avs_writedata[11:8], 1'b0,
                                        avs_writedata[6:4], 2'h0, avs_writedata[1:0]};
        `SSS_OFF_ENABLE: enable_reg <= avs_writedata[23:0];
        `SSS_OFF_MODE:   mode_reg   <= avs_writedata[23:0];
        `SSS_OFF_INT_EN: int_en_reg <= avs_writedata[23:0];
        `SSS_OFF_WET_A:  wet_level[29:0]  <= avs_writedata[29:0];
        `SSS_OFF_WET_B:  wet_level[59:30] <= avs_writedata[29:0];
        `SSS_OFF_WET_C:  wet_level[71:60] <= avs_writedata[11:0];
        default: begin
        end
      endcase
    end
  end

  // Thermal shutdown pin passes two flip-flops.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tsd_meta <= 1'b0;
      tsd_sync <= 1'b0;
    end else begin
      tsd_meta <= tsd_in;
      tsd_sync <= tsd_meta;
    end
  end

  // Interrupt status bit and line: a new event wins over the clearing read.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_change_flag <= 1'b0;
      irq_n             <= 1'b1;
      wet_en            <= 24'h0;
    end else begin
      wet_en <= next_wet_en;
      if (end_set) begin
        state_change_flag <= 1'b1;
      end else if (stat_read) begin
        state_change_flag <= 1'b0;
      end
      if (end_irq) begin
        irq_n <= 1'b0;
      end else if (stat_read) begin
        irq_n <= 1'b1;
      end
    end
  end

  // Scan state machine.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= ST_IDLE;
      idx         <= 6'h00;
      slot        <= 4'h0;
      first_cycle <= 1'b1;
      wet_cont    <= 1'b0;
      cur_state   <= 24'h0;
      ref_state   <= 24'h0;
      filter_cnt  <= 8'h00;
      sel_chan    <= 5'h00;
      sel_adc     <= 1'b0;
      conv_start  <= 1'b0;
      win_load    <= 1'b0;
      win_val     <= 13'h0000;
      per_load    <= 1'b0;
      for (k = 0; k < `SSS_VALUE_COUNT; k = k + 1) begin
        value_mem[k] <= 10'h000;
      end
    end else begin
      win_load   <= 1'b0;
      per_load   <= 1'b0;
      conv_start <= 1'b0;
      if (!run_ok) begin
        // Stopped or overheated: halt, drop currents, rebuild the reference later.
        state       <= ST_IDLE;
        wet_cont    <= 1'b0;
        first_cycle <= 1'b1;
        if (!config_reg[`SSS_CFG_START]) begin
          filter_cnt <= 8'h00;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            idx  <= 6'h00;
            slot <= 4'h0;
            if (config_reg[`SSS_CFG_POLL]) begin
              per_load <= 1'b1;
              state    <= ST_SEEK;
            end else begin
              win_val  <= STARTUP_US[12:0];
              win_load <= 1'b1;
              state    <= ST_START;
            end
          end
          ST_START: begin
            if (win_done && !win_load) begin
              wet_cont <= 1'b1;
              per_load <= 1'b1;
              state    <= ST_SEEK;
            end
          end
          ST_SEEK: begin
            if (found_ok) begin
              sel_chan <= found[4:0];
              sel_adc  <= mode_reg[found[4:0]];
              if (wet_cont) begin
                conv_start <= 1'b1;
                state      <= ST_CONV;
              end else begin
                win_val  <= (13'h0040 << wet_window_sel);
                win_load <= 1'b1;
                state    <= ST_WET;
              end
            end else begin
              // Scan complete: adopt results as the new reference.
              ref_state   <= cur_state;
              first_cycle <= 1'b0;
              if (filter_cnt != 8'hFF) begin
                filter_cnt <= filter_cnt + 8'h01;
              end
              state <= ST_WAIT;
            end
          end
          ST_WET: begin
            if (win_done && !win_load) begin
              conv_start <= 1'b1;
              state      <= ST_CONV;
            end
          end
          ST_CONV: begin
            if (conv_done && !conv_start) begin
              cur_state[sel_chan] <= conv_above;
              if (sel_adc && slot < `SSS_VALUE_COUNT) begin
                value_mem[slot] <= conv_value;
                slot            <= slot + 4'h1;
              end
              idx   <= {1'b0, sel_chan} + 6'h01;
              state <= ST_SEEK;
            end
          end
          ST_WAIT: begin
            if (per_done && !per_load) begin
              idx      <= 6'h00;
              slot     <= 4'h0;
              per_load <= 1'b1;
              state    <= ST_SEEK;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: sss_tick_div.v */
// Divider that turns enabled clock cycles into a one-cycle tick pulse.
module sss_tick_div #(
  parameter DIV = 50,
  parameter W   = 10
) (
  input  wire ref_clk,
  input  wire reset_n,
  input  wire en,
  output reg  tick
);

  reg [W-1:0] cnt;

  // Count enabled cycles and pulse once every DIV of them.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt  <= {W{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        if (cnt == DIV[W-1:0] - 1'b1) begin
          cnt  <= {W{1'b0}};
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

endmodule

/* File: sss_tick_timer.v */
// Loadable down counter of ticks whose done level rises when the count runs out.
module sss_tick_timer #(
  parameter W = 13
) (
  input  wire         ref_clk,
  input  wire         reset_n,
  input  wire         tick,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg          done
);

  reg [W-1:0] cnt;

  // A load restarts the count; done then stands until the next load.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt  <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      cnt  <= load_val;
      done <= 1'b0;
    end else if (tick && cnt != {W{1'b0}}) begin
      cnt <= cnt - 1'b1;
      if (cnt == {{(W-1){1'b0}}, 1'b1}) begin
        done <= 1'b1;
      end
    end
  end

endmodule

/* File: testbench.sv */
// Self-checking bench: register accesses, continuous and polling scans.
`include "sss_regs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, tsd_in;
  logic        conv_done, conv_above, conv_start, sel_adc, irq_n, state_change_flag;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv;
  logic [9:0]  conv_value;
  logic [4:0]  sel_chan;
  logic [23:0] wet_en, sw;
  logic [23:0] adc_log = 24'h0;
  logic [71:0] wet_level;
  logic [3:0]  lat;
  logic [4:0]  order[$];
  logic [4:0]  e4[4] = '{5'd0, 5'd2, 5'd9, 5'd11};
  int          mismatches, comparisons, n;
  sss_scan_seq #(.STARTUP_US(2)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tsd_in(tsd_in), .conv_done(conv_done),
    .conv_above(conv_above), .conv_value(conv_value), .sel_chan(sel_chan),
    .sel_adc(sel_adc), .conv_start(conv_start), .wet_en(wet_en),
    .wet_level(wet_level), .irq_n(irq_n), .state_change_flag(state_change_flag));
  sss_conv_model u_conv (.ref_clk(ref_clk), .reset_n(reset_n), .conv_start(conv_start),
    .sel_chan(sel_chan), .sw(sw), .lat(lat), .conv_done(conv_done),
    .conv_above(conv_above), .conv_value(conv_value));
  // Clock and the log of channels and paths handed to the converter.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      order.push_back(sel_chan);
      adc_log[sel_chan] <= sel_adc;
    end
  end
  // Bus write: hold the request until waitrequest is seen low, then release.
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Bus read: data are taken at the edge where waitrequest is low.
  task automatic rd(input logic [6:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Wait a bounded span for the interrupt line to go low.
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq_n !== 1'b0; i++) @(posedge ref_clk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The whole bench, every test in turn, should end inside this span.
  initial begin
    repeat (130000) @(posedge ref_clk);
    mismatches++;
    results();
  end
  initial begin
    ref_clk = 1'b0; reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 7'h00; avs_writedata = 32'h0; tsd_in = 1'b0;
    sw = 24'h000805; lat = 4'h3;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(`SSS_OFF_CONFIG); `CHK(rv, `SSS_CFG_RESET)
    rd(7'h7C); `CHK(rv, 32'h0)
    `CHK(irq_n, 1'b1)
    wr(`SSS_OFF_WET_A, 32'h0002C688); `CHK(wet_level[17:0], 18'h2C688)
    wr(`SSS_OFF_WET_C, 32'h00000FFF); `CHK(wet_level[71:60], 12'hFFF)
    $display("test registers done");
    wr(`SSS_OFF_ENABLE, 32'h00000A05);
    wr(`SSS_OFF_MODE, 32'h00000804);
    wr(`SSS_OFF_INT_EN, 32'h00000A05);
    wr(`SSS_OFF_WET_A, 32'h18000005);
    wr(`SSS_OFF_WET_B, 32'h00000010);
    order.delete();
    wr(`SSS_OFF_CONFIG, 32'h00000001);
    wait_irq(5000); `CHK(irq_n, 1'b0)
    `CHK(state_change_flag, 1'b1)
    `CHK(wet_en, 24'h000A01)
    `CHK(order.size(), 4)
    foreach (e4[i]) `CHK(order[i], e4[i])
    `CHK(adc_log, 24'h000804)
    rd(`SSS_OFF_COMP_STATE); `CHK(rv & 32'h201, 32'h1)
    rd(`SSS_OFF_CONV_A); `CHK(rv & 32'h804, 32'h804)
    rd(`SSS_OFF_VALUE_BASE); `CHK(rv[9:0], 10'h055)
    rd(`SSS_OFF_VALUE_BASE + 7'h04); `CHK(rv[9:0], 10'h175)
    rd(`SSS_OFF_INT_STAT); `CHK(rv[0], 1'b1)
    `CHK(irq_n, 1'b1)
    `CHK(state_change_flag, 1'b0)
    $display("test first scan done");
    repeat (10000) @(posedge ref_clk);
    sw <= 24'h000A04;
    repeat (20000) @(posedge ref_clk);
    sw <= 24'h000A05;
    repeat (10000) @(posedge ref_clk);
    `CHK(irq_n, 1'b1)
    `CHK(order.size(), 4)
    wait_irq(80000); `CHK(irq_n, 1'b0)
    `CHK(wet_en, 24'h000A01)
    `CHK(order.size(), 8)
    rd(`SSS_OFF_COMP_STATE); `CHK(rv & 32'h201, 32'h201)
    rd(`SSS_OFF_INT_STAT); `CHK(rv[0], 1'b1)
    rd(`SSS_OFF_STATUS); `CHK(rv[17:10] != 8'h00, 1'b1)
    $display("test second scan done");
    wr(`SSS_OFF_CONFIG, 32'h00000000);
    @(posedge ref_clk);
    `CHK(wet_en, 24'h0)
    rd(`SSS_OFF_STATUS); `CHK(rv[17:10], 8'h00)
    $display("test stop done");
    sw <= 24'h000002;
    lat <= 4'h9;
    wr(`SSS_OFF_ENABLE, 32'h0000000A);
    wr(`SSS_OFF_MODE, 32'h00000000);
    wr(`SSS_OFF_WET_A, 32'h00000808);
    order.delete();
    wr(`SSS_OFF_CONFIG, 32'h00000003);
    while (wet_en === 24'h0) @(posedge ref_clk);
    `CHK(wet_en, 24'h000002)
    n = 0;
    while (wet_en[1] === 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
    `CHK(n >= 3140 && n <= 3230, 1'b1)
    while (wet_en === 24'h0) @(posedge ref_clk);
    `CHK(wet_en, 24'h000008)
    wait_irq(8000); `CHK(irq_n, 1'b0)
    `CHK(wet_en, 24'h0)
    `CHK(order.size(), 2)
    `CHK(order[0], 5'd1)
    `CHK(order[1], 5'd3)
    rd(`SSS_OFF_COMP_STATE); `CHK(rv & 32'hA, 32'h2)
    rd(`SSS_OFF_INT_STAT); `CHK(rv[0], 1'b1)
    $display("test polling done");
    order.delete();
    tsd_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tsd_in <= 1'b0;
    wait_irq(8000); `CHK(irq_n, 1'b0)
    `CHK(order.size(), 2)
    `CHK(order[0], 5'd1)
    `CHK(order[1], 5'd3)
    $display("test thermal done");
    results();
  end
endmodule
